//--- ddw_pkg.sv
// package: command word layout, reset values and carrier types for the dual converter front end
package ddw_pkg;

  // ********************************************************
  // command word layout
  // ********************************************************
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int CHAN_BIT = 15;
  localparam int GAIN_BIT = 13;
  localparam int ACTIVE_BIT = 12;
  localparam int CODE_MSB = 11;
  localparam logic [4:0] BIT_COUNT_FULL = 5'h10;

  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic GAIN_N_RESET = 1'h0;
  localparam logic ACTIVE_RESET = 1'h0;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ********************************************************
  // carrier types
  // ********************************************************
  typedef struct packed {
    logic gain_select_n;
    logic output_active_bit;
    logic [11:0] channel_code;
  } ddw_chan_t;

  localparam ddw_chan_t CHAN_RESET = '{GAIN_N_RESET, ACTIVE_RESET, CODE_RESET};

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic sdi;
  } ddw_serial_t;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} ddw_state_t;

endpackage : ddw_pkg

//--- ddw_sync.sv
// module: two-flop synchroniser for one pin input
`timescale 1ns/1ps
`default_nettype none
module ddw_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // level
  input wire logic din,
  output logic dout
);
  logic meta_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'h1;
      dout <= 1'h1;
    end else if (clk_en) begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : ddw_sync
`default_nettype wire

//--- ddw_chan.sv
// module: one channel's input and output latches with shutdown state
`timescale 1ns/1ps
`default_nettype none
module ddw_chan (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // load and transfer
  input wire logic load,
  input wire ddw_pkg::ddw_chan_t load_val,
  input wire logic transfer,
  input wire logic standby_ok,
  // outputs
  output ddw_pkg::ddw_chan_t out_val,
  output logic out_drive,
  output logic written
);
  ddw_pkg::ddw_chan_t in_reg;

  // ********************************************************
  // input latch
  // ********************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_reg <= ddw_pkg::CHAN_RESET;
      written <= 1'h0;
    end else if (clk_en) begin
      if (load) begin
        in_reg <= load_val;
        written <= 1'h1;
      end
    end
  end

  // ********************************************************
  // output latch
  // ********************************************************
  // a load in the transfer cycle is copied at the next edge only if transfer is still asserted; that transfer copies the old value
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_val <= ddw_pkg::CHAN_RESET;
    end else if (clk_en) begin
      if (transfer && written) begin
        out_val <= in_reg;
      end
    end
  end

  // driven only when active bit latched and standby released
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_drive <= 1'h0;
    end else if (clk_en) begin
      out_drive <= standby_ok && out_val.output_active_bit;
    end
  end
endmodule : ddw_chan
`default_nettype wire

//--- ddw_top.sv
// module: serial write front end of the dual channel converter
// ********************************************************
// ********************************************************
`timescale 1ns/1ps
`default_nettype none
module ddw_top #(
  parameter bit SINGLE_CHANNEL = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // serial link pins
  input wire ddw_pkg::ddw_serial_t serial_in,
  // control pins
  input wire logic latch_transfer_n,
  input wire logic output_standby_control,
  // channel a output
  output logic [11:0] chan_a_code,
  output logic chan_a_gain_select_n,
  output logic chan_a_drive,
  // channel b output
  output logic [11:0] chan_b_code,
  output logic chan_b_gain_select_n,
  output logic chan_b_drive
);
  // no serial output port exists: the link is write only

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  logic cs_n_s;
  logic sck_s;
  logic sdi_s;
  logic latch_transfer_n_n_s;
  logic stby_s;

  ddw_sync u_sync_cs (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .din(serial_in.cs_n), .dout(cs_n_s));
  ddw_sync u_sync_sck (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .din(serial_in.sck), .dout(sck_s));
  ddw_sync u_sync_sdi (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .din(serial_in.sdi), .dout(sdi_s));
  ddw_sync u_sync_latch_transfer_n (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .din(latch_transfer_n), .dout(latch_transfer_n_n_s));
  ddw_sync u_sync_stby (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .din(output_standby_control), .dout(stby_s));

  // ********************************************************
  // edge detection
  // ********************************************************
  logic sck_d_reg;
  logic cs_n_d_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_reg <= 1'h1;
      cs_n_d_reg <= 1'h1;
    end else if (clk_en) begin
      sck_d_reg <= sck_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  // mode 0,0 and 1,1 both sample on the rise; idle level does not matter
  logic sck_rise;
  logic cs_rise;
  assign sck_rise = sck_s && !sck_d_reg;
  assign cs_rise = cs_n_s && !cs_n_d_reg;

  // ********************************************************
  // shift register and bit counter
  // ********************************************************
  ddw_pkg::ddw_state_t state_reg;
  logic [15:0] shift_reg;
  logic [4:0] count_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ddw_pkg::ST_IDLE;
    end else if (clk_en) begin
      case (state_reg)
        ddw_pkg::ST_IDLE: begin
          if (!cs_n_s) begin
            state_reg <= ddw_pkg::ST_SHIFT;
          end
        end
        ddw_pkg::ST_SHIFT: begin
          if (cs_n_s) begin
            state_reg <= ddw_pkg::ST_IDLE;
          end else if (sck_rise && count_reg == ddw_pkg::BIT_COUNT_FULL - 5'h01) begin
            state_reg <= ddw_pkg::ST_DONE;
          end
        end
        ddw_pkg::ST_DONE: begin
          if (cs_n_s) begin
            state_reg <= ddw_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= ddw_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // shifting runs regardless of shutdown so a write can wake outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= ddw_pkg::WORD_RESET;
      count_reg <= 5'h00;
    end else if (clk_en) begin
      if (cs_n_s) begin
        count_reg <= 5'h00;
      end else if (sck_rise && state_reg == ddw_pkg::ST_SHIFT) begin
        shift_reg <= {shift_reg[14:0], sdi_s};
        count_reg <= count_reg + 5'h01;
      end
      // clocks after the sixteenth fall in ST_DONE and change nothing
    end
  end

  // ********************************************************
  // word decode
  // ********************************************************
  logic word_done;
  logic load_a;
  logic load_b;
  ddw_pkg::ddw_chan_t load_val;

  // the word counts only if sixteen clocks came before the select rise
  assign word_done = cs_rise && state_reg == ddw_pkg::ST_DONE;
  assign load_a = word_done && !shift_reg[ddw_pkg::CHAN_BIT];
  assign load_b = word_done && shift_reg[ddw_pkg::CHAN_BIT] && !SINGLE_CHANNEL;
  assign load_val.gain_select_n = shift_reg[ddw_pkg::GAIN_BIT];
  assign load_val.output_active_bit = shift_reg[ddw_pkg::ACTIVE_BIT];
  assign load_val.channel_code = shift_reg[ddw_pkg::CODE_MSB:0];

  // ********************************************************
  // latch transfer and standby
  // ********************************************************
  logic transfer;
  logic standby_ok;

  // level low transfers; tied low, it fires the cycle after each load
  assign transfer = !latch_transfer_n_n_s;
  // the dual variant has no standby pin; it is ignored there
  assign standby_ok = SINGLE_CHANNEL ? stby_s : 1'b1;

  ddw_pkg::ddw_chan_t out_a;
  ddw_pkg::ddw_chan_t out_b;

  ddw_chan u_chan_a (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .load(load_a),
    .load_val(load_val),
    .transfer(transfer),
    .standby_ok(standby_ok),
    .out_val(out_a),
    .out_drive(chan_a_drive),
    .written()
  );

  ddw_chan u_chan_b (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .load(load_b),
    .load_val(load_val),
    .transfer(transfer),
    .standby_ok(standby_ok),
    .out_val(out_b),
    .out_drive(chan_b_drive),
    .written()
  );

  assign chan_a_code = out_a.channel_code;
  assign chan_a_gain_select_n = out_a.gain_select_n;
  assign chan_b_code = out_b.channel_code;
  assign chan_b_gain_select_n = out_b.gain_select_n;
endmodule : ddw_top
`default_nettype wire

//--- ddw_top_props.sv
// checker: port assertions for ddw_top
`timescale 1ns/1ps
`default_nettype none
module ddw_top_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // pins
  input wire ddw_pkg::ddw_serial_t serial_in,
  input wire logic latch_transfer_n,
  input wire logic output_standby_control,
  // outputs
  input wire logic [11:0] chan_a_code,
  input wire logic chan_a_gain_select_n,
  input wire logic chan_a_drive,
  input wire logic [11:0] chan_b_code,
  input wire logic chan_b_gain_select_n,
  input wire logic chan_b_drive
);
  // *****
  // helpers
  // *****
  // quiet: cycles since a select, transfer or standby pin event, age: since transfer pin low
  // standby counts as an event: on the single variant it moves the drive bits
  logic [3:0] quiet_reg;
  logic [3:0] age_reg;
  logic [2:0] pin_reg;
  logic [2:0] pins;
  logic [27:0] outs;
  assign pins = {serial_in.cs_n, latch_transfer_n, output_standby_control};
  assign outs = {chan_a_code, chan_a_gain_select_n, chan_a_drive,
    chan_b_code, chan_b_gain_select_n, chan_b_drive};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_reg <= 3'h7;
      quiet_reg <= 4'h0;
      age_reg <= 4'hF;
    end else if (clk_en) begin
      pin_reg <= pins;
      quiet_reg <= (pin_reg != pins) ? 4'h0
        : quiet_reg + {3'h0, quiet_reg != 4'hF};
      age_reg <= !latch_transfer_n ? 4'h0 : age_reg + {3'h0, age_reg != 4'hF};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // *****
  // assertions
  // *****
  rst_hold_a: assert property (disable iff (1'b0) !rst_n |=> outs == 28'h0)
    else $error("outputs not cleared by reset");
  rst_release_a: assert property ($rose(rst_n) |-> ##1 outs == 28'h0)
    else $error("outputs moved right after reset");
  idle_hold_a: assert property (quiet_reg >= 4'hA |-> $stable(outs))
    else $error("outputs moved with no pin event");
  drive_on_a: assert property ($rose(chan_a_drive) || $rose(chan_b_drive)
    |-> quiet_reg <= 4'h9)
    else $error("drive rose with no cause");
  drive_off_a: assert property ($fell(chan_a_drive) || $fell(chan_b_drive)
    |-> quiet_reg <= 4'h9)
    else $error("drive fell with no cause");
  code_gate_a: assert property ($changed({chan_a_code, chan_b_code})
    |-> age_reg <= 4'h6)
    else $error("code changed without transfer");
  gain_gate_a: assert property ($changed({chan_a_gain_select_n, chan_b_gain_select_n})
    |-> age_reg <= 4'h6)
    else $error("gain changed without transfer");
  en_freeze_a: assert property (!clk_en |=> $stable(outs))
    else $error("outputs moved while disabled");
  cover property ($rose(chan_a_drive));
  cover property ($rose(chan_b_drive));
  cover property ($fell(chan_a_drive));
endmodule : ddw_top_props

bind ddw_top ddw_top_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
  .serial_in(serial_in), .latch_transfer_n(latch_transfer_n),
  .output_standby_control(output_standby_control), .chan_a_code(chan_a_code),
  .chan_a_gain_select_n(chan_a_gain_select_n), .chan_a_drive(chan_a_drive),
  .chan_b_code(chan_b_code), .chan_b_gain_select_n(chan_b_gain_select_n),
  .chan_b_drive(chan_b_drive));
`default_nettype wire

//--- ddw_host.sv
// partner: host serial controller on the write-only link
`timescale 1ns/1ps
`default_nettype none
module ddw_host (
  // link pins
  output var ddw_pkg::ddw_serial_t serial
);
  // cs_n high, sck high, sdi low
  initial serial = 3'b110;
  // bits past 16 toggle data, used to test that clocks after the sixteenth are ignored
  task automatic send(input logic [15:0] w, input int n, input logic mode);
    // quarter-cycle offset keeps pin moves clear of the sampling edges in every send but the one after stray, where they land on the edges
    #1.25;
    serial.sck = mode;
    #62.5;
    serial.cs_n = 1'b0;
    #62.5;
    for (int i = 0; i < n; i++) begin
      serial.sck = 1'b0;
      serial.sdi = (i < 16) ? w[15 - i] : ~serial.sdi;
      #62.5;
      serial.sck = 1'b1;
      #62.5;
    end
    serial.sck = mode;
    #62.5;
    serial.cs_n = 1'b1;
    serial.sdi = ~serial.sdi;
    #125;
  endtask : send
  task automatic stray(input int n);
    #1.25;
    for (int i = 0; i < n; i++) begin
      serial.sdi = ~serial.sdi;
      serial.sck = ~serial.sck;
      #62.5;
    end
  endtask : stray
endmodule : ddw_host
`default_nettype wire

//--- test_ddw_top.sv
// testbench: serial writes, transfers and refusals for ddw_top
`timescale 1ns/1ps
`default_nettype none
module test_ddw_top;
  // *****
  // harness
  // *****
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic latch_transfer_n = 1'b1;
  logic output_standby_control = 1'b1;
  ddw_pkg::ddw_serial_t serial_in;
  logic [11:0] a_code, b_code;
  logic a_gain, a_drv, b_gain, b_drv;
  wire logic [13:0] a_out = {a_code, a_gain, a_drv};
  wire logic [13:0] b_out = {b_code, b_gain, b_drv};
  logic [11:0] sa_code, sb_code;
  logic sa_gain, sa_drv, sb_gain, sb_drv;
  wire logic [13:0] sa_out = {sa_code, sa_gain, sa_drv};
  wire logic [13:0] sb_out = {sb_code, sb_gain, sb_drv};
  int bad_count = 0;
  int compares = 0;
  always #2.5 clk_sys = ~clk_sys;
  ddw_host host (.serial(serial_in));
  ddw_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .serial_in(serial_in),
    .latch_transfer_n(latch_transfer_n), .output_standby_control(output_standby_control),
    .chan_a_code(a_code), .chan_a_gain_select_n(a_gain), .chan_a_drive(a_drv),
    .chan_b_code(b_code), .chan_b_gain_select_n(b_gain), .chan_b_drive(b_drv));
  // single variant on the same pins: standby pin live, channel b never loads
  ddw_top #(.SINGLE_CHANNEL(1'b1)) dut_single (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(clk_en), .serial_in(serial_in), .latch_transfer_n(latch_transfer_n),
    .output_standby_control(output_standby_control),
    .chan_a_code(sa_code), .chan_a_gain_select_n(sa_gain), .chan_a_drive(sa_drv),
    .chan_b_code(sb_code), .chan_b_gain_select_n(sb_gain), .chan_b_drive(sb_drv));
  task automatic close_out;
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  // channel result is {code, gain_n, drive}
  task automatic chk(input string nm, input logic [13:0] exp, input logic [13:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // pause covers sync, latch and drive stages
  task automatic wr(input logic [15:0] w, input int n, input logic mode);
    host.send(w, n, mode);
    repeat (12) @(negedge clk_sys);
  endtask : wr
  task automatic pause(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : pause
  // *****
  // tests
  // *****
  initial begin
    pause(20);
    rst_n = 1'b1;
    pause(4);
    chk("a", 14'h0, a_out);
    chk("b", 14'h0, b_out);
    wr(16'h3ABC, 16, 1'b0);
    wr(16'hDFFF, 16, 1'b1);
    chk("a", 14'h0, a_out);
    latch_transfer_n = 1'b0;
    pause(8);
    chk("a", {12'hABC, 2'h3}, a_out);
    chk("b", {12'hFFF, 2'h1}, b_out);
    chk("sa", {12'hABC, 2'h3}, sa_out);
    chk("sb", 14'h0, sb_out);
    wr(16'h0000, 16, 1'b1);
    chk("a", 14'h0, a_out);
    wr(16'hB123, 15, 1'b0);
    chk("b", {12'hFFF, 2'h1}, b_out);
    wr(16'h35A5, 20, 1'b0);
    chk("a", {12'h5A5, 2'h3}, a_out);
    host.stray(8);
    wr(16'h8000, 8, 1'b0);
    chk("a", {12'h5A5, 2'h3}, a_out);
    chk("b", {12'hFFF, 2'h1}, b_out);
    output_standby_control = 1'b0;
    clk_en = 1'b0;
    pause(4);
    clk_en = 1'b1;
    pause(8);
    chk("b", {12'hFFF, 2'h1}, b_out);
    chk("sa", {12'h5A5, 2'h2}, sa_out);
    output_standby_control = 1'b1;
    pause(8);
    chk("sa", {12'h5A5, 2'h3}, sa_out);
    rst_n = 1'b0;
    pause(2);
    chk("a", 14'h0, a_out);
    rst_n = 1'b1;
    pause(4);
    wr(16'h1FFF, 16, 1'b1);
    chk("a", {12'hFFF, 2'h1}, a_out);
    chk("b", 14'h0, b_out);
    chk("sa", {12'hFFF, 2'h1}, sa_out);
    chk("sb", 14'h0, sb_out);
    close_out;
  end
  // about twelve times the expected run
  initial begin
    repeat (40000) @(posedge clk_sys);
    bad_count++;
    close_out;
  end
endmodule : test_ddw_top
`default_nettype wire
